// [design/lecp_lane_counter.sv]
`timescale 1ns/1ps
`default_nettype none
module lecp_lane_counter
    import lecp_pkg::*;
#(
    parameter int W = LECP_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control
    input wire logic clear,
    input wire logic [4:0] events,
    input wire logic [2:0] source_sel,
    // Count
    output logic [W-1:0] count
);

    typedef struct packed {
        logic [W-1:0] count;
    } lecp_cnt_s;

    lecp_cnt_s st;
    lecp_cnt_s next_st;
    logic hit;

    // Reserved codes count nothing
    always_comb begin
        hit = 1'b0;
        unique case (source_sel)
            LECP_SRC_DISPARITY: hit = events[0];
            LECP_SRC_FIFO_ERR: hit = events[1];
            LECP_SRC_FIFO_OVF: hit = events[2];
            LECP_SRC_FIFO_UNF: hit = events[3];
            LECP_SRC_DESKEW: hit = events[4];
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.count = '0;
        end else if (hit && st.count != {W{1'b1}}) begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;

    AST_SATURATE: assert property (@(posedge clk) disable iff (sys_rst)
        (!clear && st.count == {W{1'b1}}) |=> st.count == {W{1'b1}})
        else $error("counter wrapped past maximum");

    AST_CLEARED: assert property (@(posedge clk) disable iff (sys_rst)
        clear |=> st.count == '0)
        else $error("counter not cleared");

    AST_RESERVED_SRC: assert property (@(posedge clk) disable iff (sys_rst)
        (source_sel > LECP_SRC_DESKEW && !clear) |=> $stable(st.count))
        else $error("reserved source counted");

endmodule : lecp_lane_counter
`default_nettype wire

// [design/lecp_pkg.sv]
`default_nettype none
package lecp_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] LECP_OFS_CLEAR_CTRL = 8'h15;
    localparam logic [7:0] LECP_OFS_SOURCE_SEL = 8'h16;
    localparam logic [7:0] LECP_OFS_L2_LOW = 8'h1C;
    localparam logic [7:0] LECP_OFS_L2_HIGH = 8'h1D;
    localparam logic [7:0] LECP_OFS_L3_LOW = 8'h1E;
    localparam logic [7:0] LECP_OFS_L3_HIGH = 8'h1F;
    localparam logic [7:0] LECP_OFS_POWER = 8'h20;
    localparam logic [7:0] LECP_OFS_POWER_CTRL = 8'h09;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int LECP_BIT_CLEAR = 4;
    localparam int LECP_BIT_SOFT_PDN = 3;
    localparam int LECP_BIT_PDN_FLAG = 7;
    localparam int LECP_BIT_STB_FLAG = 6;
    localparam int LECP_CNT_W = 12;
    localparam logic [7:0] LECP_RST_BYTE = 8'h00;
    localparam logic [2:0] LECP_RST_SEL = 3'h0;

    // ------------------------------------------------------------
    // Error source codes
    // ------------------------------------------------------------
    localparam logic [2:0] LECP_SRC_DISPARITY = 3'h0;
    localparam logic [2:0] LECP_SRC_FIFO_ERR = 3'h1;
    localparam logic [2:0] LECP_SRC_FIFO_OVF = 3'h2;
    localparam logic [2:0] LECP_SRC_FIFO_UNF = 3'h3;
    localparam logic [2:0] LECP_SRC_DESKEW = 3'h4;

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LECP_PWR_NORMAL = 2'b00,
        LECP_PWR_STANDBY = 2'b01,
        LECP_PWR_DOWN = 2'b11
    } lecp_pwr_e;

endpackage : lecp_pkg
`default_nettype wire

// [design/lecp_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module lecp_regs
    import lecp_pkg::*;
#(
    parameter int W = LECP_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Device pins and link status
    input wire logic enable_pin,
    input wire logic sink_hotplug_in,
    input wire logic clock_valid,
    // Error events from the verifier, lanes 2 and 3
    input wire logic [4:0] lane2_events,
    input wire logic [4:0] lane3_events,
    // Status out
    output logic powerdown_flag,
    output logic standby_flag,
    output logic [2:0] error_source_select,
    output logic error_count_clear
);

    typedef struct packed {
        logic [7:0] rdata;
        logic clear_bit;
        logic clear_prev;
        logic soft_pdn;
        logic [2:0] src_sel;
        lecp_pwr_e pwr;
        logic pdn_flag;
        logic stb_flag;
        logic clear_pulse;
    } lecp_regs_s;

    lecp_regs_s st;
    lecp_regs_s next_st;
    logic [W-1:0] lane2_error_count;
    logic [W-1:0] lane3_error_count;

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    lecp_lane_counter #(.W(W)) u_lane2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(st.clear_pulse),
        .events(lane2_events),
        .source_sel(st.src_sel),
        .count(lane2_error_count)
    );

    lecp_lane_counter #(.W(W)) u_lane3 (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(st.clear_pulse),
        .events(lane3_events),
        .source_sel(st.src_sel),
        .count(lane3_error_count)
    );

    function automatic logic [7:0] high_nibble(input logic [W-1:0] c);
        high_nibble = {4'h0, c[11:8]};
    endfunction : high_nibble

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Clear bit self-resets one cycle after it is set
        next_st.clear_bit = 1'b0;
        if (reg_wr && reg_addr == LECP_OFS_CLEAR_CTRL) begin
            next_st.clear_bit = reg_wdata[LECP_BIT_CLEAR];
        end
        next_st.clear_prev = st.clear_bit;
        next_st.clear_pulse = st.clear_bit && !st.clear_prev;
        if (reg_wr && reg_addr == LECP_OFS_SOURCE_SEL) begin
            next_st.src_sel = reg_wdata[2:0];
        end
        if (reg_wr && reg_addr == LECP_OFS_POWER_CTRL) begin
            next_st.soft_pdn = reg_wdata[LECP_BIT_SOFT_PDN];
        end
        // Power-down outranks standby
        if (!enable_pin || !sink_hotplug_in || st.soft_pdn) begin
            next_st.pwr = LECP_PWR_DOWN;
        end else if (!clock_valid) begin
            next_st.pwr = LECP_PWR_STANDBY;
        end else begin
            next_st.pwr = LECP_PWR_NORMAL;
        end
        // Flags get their own flops so the pins carry no decode glitches
        next_st.pdn_flag = (next_st.pwr == LECP_PWR_DOWN);
        next_st.stb_flag = (next_st.pwr == LECP_PWR_STANDBY);
        next_st.rdata = st.rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                LECP_OFS_L2_LOW: next_st.rdata = lane2_error_count[7:0];
                LECP_OFS_L2_HIGH: next_st.rdata = high_nibble(lane2_error_count);
                LECP_OFS_L3_LOW: next_st.rdata = lane3_error_count[7:0];
                LECP_OFS_L3_HIGH: next_st.rdata = high_nibble(lane3_error_count);
                LECP_OFS_POWER: next_st.rdata = {st.pwr == LECP_PWR_DOWN,
                    st.pwr == LECP_PWR_STANDBY, 6'h00};
                LECP_OFS_SOURCE_SEL: next_st.rdata = {5'h00, st.src_sel};
                LECP_OFS_POWER_CTRL: next_st.rdata = {4'h0, st.soft_pdn, 3'h0};
                default: next_st.rdata = LECP_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{rdata: LECP_RST_BYTE, clear_bit: 1'b0, clear_prev: 1'b0,
                    soft_pdn: 1'b0, src_sel: LECP_RST_SEL, pwr: LECP_PWR_NORMAL,
                    pdn_flag: 1'b0, stb_flag: 1'b0, clear_pulse: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rdata;
    assign powerdown_flag = st.pdn_flag;
    assign standby_flag = st.stb_flag;
    assign error_source_select = st.src_sel;
    assign error_count_clear = st.clear_pulse;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence clear_write;
        reg_wr && reg_addr == LECP_OFS_CLEAR_CTRL && reg_wdata[LECP_BIT_CLEAR];
    endsequence

    AST_CLEAR_EDGE: assert property (@(posedge clk) disable iff (sys_rst)
        clear_write ##1 !st.clear_prev |=> st.clear_pulse ##1 lane2_error_count == '0)
        else $error("clear write did not zero counter");

    AST_PDN_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        (!enable_pin || !sink_hotplug_in) |=> powerdown_flag)
        else $error("power-down not flagged");

    AST_STB_FLAG: assert property (@(posedge clk) disable iff (sys_rst)
        (enable_pin && sink_hotplug_in && !st.soft_pdn && !clock_valid) |=> standby_flag)
        else $error("standby not flagged");

    AST_PWR_READ: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_POWER) |=>
        reg_rdata == {$past(powerdown_flag), $past(standby_flag), 6'h00})
        else $error("power status read mismatch");

    AST_RESV_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_POWER) |=> reg_rdata[5:0] == 6'h00)
        else $error("reserved power bits nonzero");

    AST_L2_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_L2_LOW) |=> reg_rdata == $past(lane2_error_count[7:0]))
        else $error("lane 2 low byte mismatch");

    AST_L2_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_L2_HIGH) |=>
        reg_rdata == {4'h0, $past(lane2_error_count[11:8])})
        else $error("lane 2 high byte mismatch");

    AST_L3_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_L3_LOW) |=> reg_rdata == $past(lane3_error_count[7:0]))
        else $error("lane 3 low byte mismatch");

    AST_L3_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == LECP_OFS_L3_HIGH) |=>
        reg_rdata == {4'h0, $past(lane3_error_count[11:8])})
        else $error("lane 3 high byte mismatch");

    AST_EXCLUSIVE: assert property (@(posedge clk) disable iff (sys_rst)
        !(powerdown_flag && standby_flag))
        else $error("both power flags set");

    sequence clear_pulse_seen;
        st.clear_pulse;
    endsequence

    AST_CLEAR_EDGE_L3: assert property (@(posedge clk) disable iff (sys_rst)
        clear_write ##1 !st.clear_prev |=> clear_pulse_seen ##1 lane3_error_count == '0)
        else $error("clear write did not zero lane 3 counter");

    AST_CLEAR_ONCE: assert property (@(posedge clk) disable iff (sys_rst)
        error_count_clear |=> !error_count_clear)
        else $error("clear pulse longer than one cycle");

    AST_SOFT_PDN: assert property (@(posedge clk) disable iff (sys_rst)
        st.soft_pdn |=> powerdown_flag)
        else $error("soft power-down not flagged");

    AST_NORMAL: assert property (@(posedge clk) disable iff (sys_rst)
        (enable_pin && sink_hotplug_in && !st.soft_pdn && clock_valid) |=>
        (!powerdown_flag && !standby_flag))
        else $error("power flag set in normal operation");

    AST_SRC_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == LECP_OFS_SOURCE_SEL) |=>
        error_source_select == $past(reg_wdata[2:0]))
        else $error("source select write lost");

    AST_HIGH_RESV: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && (reg_addr == LECP_OFS_L2_HIGH || reg_addr == LECP_OFS_L3_HIGH)) |=>
        reg_rdata[7:4] == 4'h0)
        else $error("reserved count bits nonzero");

endmodule : lecp_regs
`default_nettype wire

// [tb/lecp_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lane_error_count_power_status_regs_tb;
    import lecp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic enable_pin = 1'b1;
    logic sink_hotplug_in = 1'b1;
    logic clock_valid = 1'b1;
    logic [4:0] lane2_events = 5'h00;
    logic [4:0] lane3_events = 5'h00;
    logic powerdown_flag;
    logic standby_flag;
    logic [2:0] error_source_select;
    logic error_count_clear;
    logic [7:0] exp_q[$];
    logic rd_pend = 1'b0;
    int fails = 0;
    int n_tests = 0;
    int n_clr = 0;
    int exp_clr = 0;
    int seed = 32'h70C0;

    always #20 clk = ~clk;

    lecp_regs lecp_regs_inst (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enable_pin(enable_pin), .sink_hotplug_in(sink_hotplug_in),
        .clock_valid(clock_valid), .lane2_events(lane2_events),
        .lane3_events(lane3_events), .powerdown_flag(powerdown_flag),
        .standby_flag(standby_flag), .error_source_select(error_source_select),
        .error_count_clear(error_count_clear)
    );

    // ------------------------------------------------------------
    // Bus tasks and compare
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Pin outputs are judged directly, they stand until the state moves
    task automatic check_pins(input logic [7:0] got, input logic [7:0] exp);
        check(got, exp);
    endtask : check_pins

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        exp_q.push_back(exp);
        @(negedge clk);
        reg_rd = 1'b0;
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Monitor: read data lands on the read edge, so judge it half a cycle on
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_pend <= reg_rd && !sys_rst;
    end

    // Pulse is counted mid-cycle, away from the edge that launches it
    always @(negedge clk) begin
        if (!sys_rst && error_count_clear === 1'b1) begin
            n_clr++;
        end
        if (rd_pend) begin
            check(reg_rdata, exp_q.pop_front());
        end
    end

    initial begin
        #(40 * 20000);
        fails++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [4:0] r;
        logic [11:0] e;
        logic [7:0] p;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        check_pins({5'h00, error_source_select}, 8'h00);
        check_pins({6'h00, powerdown_flag, standby_flag}, 8'h00);
        for (int a = 'h1C; a <= 'h20; a++) rd(8'(a), 8'h00);
        wr(8'h30, 8'hFF);
        rd(8'h30, 8'h00);
        rd(LECP_OFS_CLEAR_CTRL, 8'h00);
        // Codes 5 to 7 must count nothing even with random events driven on all five lines
        for (int s = 0; s < 8; s++) begin
            wr(LECP_OFS_SOURCE_SEL, 8'(s));
            check_pins({5'h00, error_source_select}, 8'(s));
            rd(LECP_OFS_SOURCE_SEL, 8'(s));
            wr(LECP_OFS_CLEAR_CTRL, 8'h10);
            exp_clr++;
            idle(4);
            n = 1 + ($unsigned($random(seed)) % 300);
            for (int k = 0; k < n; k++) begin
                r = 5'($random(seed));
                lane2_events = (s < 5) ? (r | (5'h01 << s)) : r;
                lane3_events = (s < 5) ? (r & ~(5'h01 << s)) : r;
                @(negedge clk);
            end
            lane2_events = 5'h00;
            lane3_events = 5'h00;
            e = (s < 5) ? 12'(n) : 12'h000;
            rd(LECP_OFS_L2_LOW, e[7:0]);
            rd(LECP_OFS_L2_HIGH, {4'h0, e[11:8]});
            rd(LECP_OFS_L3_LOW, 8'h00);
            rd(LECP_OFS_L3_HIGH, 8'h00);
        end
        wr(LECP_OFS_SOURCE_SEL, {5'h00, LECP_SRC_DESKEW});
        lane2_events = 5'h10;
        lane3_events = 5'h1F;
        idle(4100);
        lane2_events = 5'h00;
        lane3_events = 5'h00;
        rd(LECP_OFS_L2_LOW, 8'hFF);
        rd(LECP_OFS_L2_HIGH, 8'h0F);
        rd(LECP_OFS_L3_LOW, 8'hFF);
        rd(LECP_OFS_L3_HIGH, 8'h0F);
        wr(LECP_OFS_L3_LOW, 8'h55);
        rd(LECP_OFS_L3_LOW, 8'hFF);
        wr(LECP_OFS_CLEAR_CTRL, 8'h00);
        rd(LECP_OFS_L2_LOW, 8'hFF);
        wr(LECP_OFS_CLEAR_CTRL, 8'h10);
        exp_clr++;
        idle(4);
        rd(LECP_OFS_L2_LOW, 8'h00);
        rd(LECP_OFS_L3_HIGH, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(LECP_OFS_POWER_CTRL, {4'h0, i[3], 3'h0});
            enable_pin = i[0];
            sink_hotplug_in = i[1];
            clock_valid = i[2];
            idle(2);
            p = (!i[0] || !i[1] || i[3]) ? 8'h80 : (!i[2] ? 8'h40 : 8'h00);
            check_pins({6'h00, powerdown_flag, standby_flag}, {6'h00, p[7:6]});
            rd(LECP_OFS_POWER, p);
            rd(LECP_OFS_POWER_CTRL, {4'h0, i[3], 3'h0});
        end
        idle(3);
        check(8'(n_clr), 8'(exp_clr));
        summarize();
    end
endmodule : lane_error_count_power_status_regs_tb
`default_nettype wire
